// ### src/odes_pkg.sv
// constants, register map and carriers for the output driver enable sequencer
// assumes a 10 MHz clock and a classic wishbone slave with 32-bit data
package odes_pkg;
  // printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_HP_ENABLE = 8'h0e;
  localparam logic [7:0] IDX_LINE_ENABLE = 8'h0f;
  localparam logic [7:0] IDX_DAC_CTRL_ONE = 8'h21;
  localparam logic [7:0] IDX_HP_POP = 8'h5a;
  localparam logic [7:0] IDX_LINE_POP = 8'h5e;
  localparam logic [7:0] IDX_OUT_MUX = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam int ADDR_W = 10;
  localparam int REG_W = 16;
  // field positions
  localparam int BIT_AMP_LEFT = 1;
  localparam int BIT_AMP_RIGHT = 0;
  localparam int BIT_OSR = 6;
  localparam int BIT_L_SHORT = 7;
  localparam int BIT_L_OUTP = 6;
  localparam int BIT_L_MID = 5;
  localparam int BIT_L_IN = 4;
  localparam int BIT_R_SHORT = 3;
  localparam int BIT_R_OUTP = 2;
  localparam int BIT_R_MID = 1;
  localparam int BIT_R_IN = 0;
  localparam int POP_W = 8;
  localparam int MUX_W = 4;
  localparam int AMP_W = 2;
  localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
  // dac control one resets with soft mute set
  localparam logic [REG_W-1:0] RST_DAC_CTRL = 16'h0008;
  // all four outputs sit shorted to ground out of reset
  localparam logic [3:0] RST_SHORTED = 4'hf;
  // input stage settle time before the mid stage may follow
  localparam int SETTLE_US = 20;
  localparam int CLK_MHZ = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

  typedef struct packed {
    logic short_release;
    logic output_stage;
    logic mid_stage;
    logic input_stage;
  } odes_chan_type;

  typedef struct packed {
    odes_chan_type left;
    odes_chan_type right;
  } odes_pair_type;

  typedef struct packed {
    logic [AMP_W-1:0] hp_amp;
    logic [AMP_W-1:0] line_amp;
    logic dac_double_oversample;
    logic [MUX_W-1:0] out_mux;
    odes_pair_type hp;
    odes_pair_type line;
    logic [3:0] short_to_ground;
  } odes_ctrl_type;
endpackage

// ### src/odes_top.sv
// register file and analogue output control for the output driver sequencer
// assumes a classic wishbone master on clk_i; analogue blocks take ctrl_o
//
// Behaviour
// - oversample bit doubles DAC rate, resets clear
// - outputs take DAC unless mux picks bypass
// - four amp enables at bits one, zero
// - outputs grounded until short release set
// - left headphone pop bits seven to five
// - headphone left input bit four, right three-zero
// - line pop left bits seven to five
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
module odes_top #(
  parameter int SETTLE_CYCLES = odes_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [odes_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output odes_pkg::odes_ctrl_type ctrl_o,
  output logic [3:0] settle_wait_o
);
  logic [odes_pkg::REG_W-1:0] hp_en, line_en, dac_ctrl, hp_pop, line_pop, out_mux;
  logic [odes_pkg::REG_W-1:0] next_hp_en, next_line_en, next_dac_ctrl;
  logic [odes_pkg::REG_W-1:0] next_hp_pop, next_line_pop, next_out_mux;
  logic [31:0] next_dat;
  logic next_ack;
  odes_pkg::odes_ctrl_type next_ctrl;
  logic [3:0] next_wait;
  logic [3:0] in_bits, mid_bits;
  logic [7:0] idx;
  logic req;

  function automatic logic [odes_pkg::REG_W-1:0] merge(
    input logic [odes_pkg::REG_W-1:0] old_val,
    input logic [31:0] wr,
    input logic [3:0] sel);
    logic [odes_pkg::REG_W-1:0] res;
    res = old_val;
    // lanes above the register width are ignored
    for (int lane = 0; lane < odes_pkg::REG_W / 8; lane++) begin
      if (sel[lane]) begin
        res[lane*8 +: 8] = wr[lane*8 +: 8];
      end
    end
    return res;
  endfunction

  // a pop control nibble maps straight onto the channel carrier
  function automatic odes_pkg::odes_chan_type chan(input logic [3:0] f);
    chan = f;
  endfunction

  assign idx = adr_i[odes_pkg::ADDR_W-1:2];
  assign req = cyc_i && stb_i && !ack_o;
  assign in_bits = {hp_pop[odes_pkg::BIT_L_IN], hp_pop[odes_pkg::BIT_R_IN],
                    line_pop[odes_pkg::BIT_L_IN], line_pop[odes_pkg::BIT_R_IN]};
  assign mid_bits = {hp_pop[odes_pkg::BIT_L_MID], hp_pop[odes_pkg::BIT_R_MID],
                     line_pop[odes_pkg::BIT_L_MID], line_pop[odes_pkg::BIT_R_MID]};

  // writes land at the edge that takes the request; unmapped indices are ignored
  always_comb begin
    next_hp_en = hp_en;
    next_line_en = line_en;
    next_dac_ctrl = dac_ctrl;
    next_hp_pop = hp_pop;
    next_line_pop = line_pop;
    next_out_mux = out_mux;
    if (req && we_i) begin
      unique case (idx)
        odes_pkg::IDX_HP_ENABLE: next_hp_en = merge(hp_en, dat_i, sel_i);
        odes_pkg::IDX_LINE_ENABLE: next_line_en = merge(line_en, dat_i, sel_i);
        odes_pkg::IDX_DAC_CTRL_ONE: next_dac_ctrl = merge(dac_ctrl, dat_i, sel_i);
        odes_pkg::IDX_HP_POP: next_hp_pop = merge(hp_pop, dat_i, sel_i);
        odes_pkg::IDX_LINE_POP: next_line_pop = merge(line_pop, dat_i, sel_i);
        odes_pkg::IDX_OUT_MUX: next_out_mux = merge(out_mux, dat_i, sel_i);
        default: ;
      endcase
    end
    // unused bits of each register except dac control one are kept zero
    next_hp_en[odes_pkg::REG_W-1:odes_pkg::AMP_W] = '0;
    next_line_en[odes_pkg::REG_W-1:odes_pkg::AMP_W] = '0;
    next_hp_pop[odes_pkg::REG_W-1:odes_pkg::POP_W] = '0;
    next_line_pop[odes_pkg::REG_W-1:odes_pkg::POP_W] = '0;
    next_out_mux[odes_pkg::REG_W-1:odes_pkg::MUX_W] = '0;
  end

  // read data is registered and stands only in the ack cycle
  always_comb begin
    next_dat = 32'h0000_0000;
    next_ack = req;
    if (req && !we_i) begin
      unique case (idx)
        odes_pkg::IDX_HP_ENABLE: next_dat = {16'h0000, hp_en};
        odes_pkg::IDX_LINE_ENABLE: next_dat = {16'h0000, line_en};
        odes_pkg::IDX_DAC_CTRL_ONE: next_dat = {16'h0000, dac_ctrl};
        odes_pkg::IDX_HP_POP: next_dat = {16'h0000, hp_pop};
        odes_pkg::IDX_LINE_POP: next_dat = {16'h0000, line_pop};
        odes_pkg::IDX_OUT_MUX: next_dat = {16'h0000, out_mux};
        odes_pkg::IDX_STATUS: next_dat = {28'h0000000, settle_wait_o};
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  // one settle counter per input stage, bit 3 down to 0: hp l, hp r, line l, line r
  for (genvar g = 0; g < 4; g++) begin : gen_settle
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_hold;

    // the count restarts whenever the input stage drops, so a quick off-on
    // cannot reuse an old settle time; a settle count above 16 bits is cut
    always_comb begin
      next_cnt = cnt;
      if (!in_bits[g]) begin
        next_cnt = 16'h0000;
      end else if (cnt < 16'(SETTLE_CYCLES)) begin
        next_cnt = cnt + 16'h0001;
      end
      // the present count is used so the hold spans the full settle time
      next_hold = in_bits[g] && (cnt < 16'(SETTLE_CYCLES));
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt <= 16'h0000;
      end else begin
        cnt <= next_cnt;
      end
    end

    assign next_wait[g] = next_hold;
  end

  // controls are registered once more, so they trail a write by two edges
  always_comb begin
    next_ctrl.hp_amp = hp_en[odes_pkg::AMP_W-1:0];
    next_ctrl.line_amp = line_en[odes_pkg::AMP_W-1:0];
    next_ctrl.dac_double_oversample = dac_ctrl[odes_pkg::BIT_OSR];
    next_ctrl.out_mux = out_mux[odes_pkg::MUX_W-1:0];
    next_ctrl.hp.left = chan(hp_pop[odes_pkg::BIT_L_SHORT:odes_pkg::BIT_L_IN]);
    next_ctrl.hp.right = chan(hp_pop[odes_pkg::BIT_R_SHORT:odes_pkg::BIT_R_IN]);
    next_ctrl.line.left = chan(line_pop[odes_pkg::BIT_L_SHORT:odes_pkg::BIT_L_IN]);
    next_ctrl.line.right = chan(line_pop[odes_pkg::BIT_R_SHORT:odes_pkg::BIT_R_IN]);
    // a mid stage asked for while its input stage is on but not yet settled is held off in hardware
    next_ctrl.hp.left.mid_stage = mid_bits[3] && !next_wait[3];
    next_ctrl.hp.right.mid_stage = mid_bits[2] && !next_wait[2];
    next_ctrl.line.left.mid_stage = mid_bits[1] && !next_wait[1];
    next_ctrl.line.right.mid_stage = mid_bits[0] && !next_wait[0];
    next_ctrl.short_to_ground = ~{hp_pop[odes_pkg::BIT_L_SHORT], hp_pop[odes_pkg::BIT_R_SHORT],
                                  line_pop[odes_pkg::BIT_L_SHORT],
                                  line_pop[odes_pkg::BIT_R_SHORT]};
  end

  // register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hp_en <= odes_pkg::RST_ZERO;
      line_en <= odes_pkg::RST_ZERO;
      dac_ctrl <= odes_pkg::RST_DAC_CTRL;
      hp_pop <= odes_pkg::RST_ZERO;
      line_pop <= odes_pkg::RST_ZERO;
      out_mux <= odes_pkg::RST_ZERO;
    end else begin
      hp_en <= next_hp_en;
      line_en <= next_line_en;
      dac_ctrl <= next_dac_ctrl;
      hp_pop <= next_hp_pop;
      line_pop <= next_line_pop;
      out_mux <= next_out_mux;
    end
  end

  // bus answer: ack_o drops the cycle after it rose even if stb_i is still high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
    end else begin
      dat_o <= next_dat;
      ack_o <= next_ack;
    end
  end

  // analogue controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
      ctrl_o.short_to_ground <= odes_pkg::RST_SHORTED;
    end else begin
      ctrl_o <= next_ctrl;
    end
  end

  // settle status, readable so software can see a held mid stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_wait_o <= 4'h0;
    end else begin
      settle_wait_o <= next_wait;
    end
  end
endmodule

// ### tb/odes_checker.sv
// port assertions for odes_top
// bound below; sees only the top module's ports
`timescale 1ns/10ps
module odes_checker #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [odes_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire odes_pkg::odes_ctrl_type ctrl_o,
  input wire logic [3:0] settle_wait_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ack;
  assign wr_ack = ack_o && we_i && sel_i[0];
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  ground_map_a: assert property (ctrl_o.short_to_ground == ~{ctrl_o.hp.left.short_release,
    ctrl_o.hp.right.short_release, ctrl_o.line.left.short_release,
    ctrl_o.line.right.short_release}) else $error("short state wrong");
  mid_gate_a: assert property (ctrl_o.hp.left.mid_stage |->
    ctrl_o.hp.left.input_stage && !settle_wait_o[3]) else $error("mid stage early");
  mid_hold_a: assert property ($rose(ctrl_o.line.right.input_stage) |->
    !ctrl_o.line.right.mid_stage [*8]) else $error("mid stage not held");
  osr_set_a: assert property (wr_ack && adr_i[9:2] == odes_pkg::IDX_DAC_CTRL_ONE |->
    ##2 ctrl_o.dac_double_oversample == $past(dat_i[6], 2)) else $error("oversample wrong");
  amp_set_a: assert property (wr_ack && adr_i[9:2] == odes_pkg::IDX_HP_ENABLE |->
    ##2 ctrl_o.hp_amp == $past(dat_i[1:0], 2)) else $error("amp enable wrong");
  read_high_a: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  cover property (wr_ack);
  cover property ($rose(ctrl_o.hp.left.mid_stage));
  cover property ($fell(ctrl_o.short_to_ground[3]));
endmodule
bind odes_top odes_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_odes_checker (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ctrl_o(ctrl_o), .settle_wait_o(settle_wait_o));

// ### tb/odes_host.sv
// controller model: classic single wishbone cycles
// shares the sequencer's clock; holds each request until ack
`timescale 1ns/10ps
module odes_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [9:0] adr_o = 10'h000,
  output logic [3:0] sel_o = 4'h3,
  output logic [31:0] dat_o = 32'h00000000
);
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= {idx, 2'b00};
    dat_o <= {16'h0000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[15:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released data must not look like the last value
    dat_o <= ~{16'h0000, d};
  endtask
endmodule

// ### tb/tb_odes_top.sv
// bench: register traffic and enable sequences via the host model
// settle count cut to 8 cycles to keep the run short
`timescale 1ns/10ps
module tb_odes_top;
  localparam int SETTLE = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i, settle_wait_o;
  logic [31:0] dat_i, dat_o;
  odes_pkg::odes_ctrl_type ctrl_o;
  logic [15:0] q;
  logic [7:0] idx[5] = '{8'h0e, 8'h0f, 8'h21, 8'h5a, 8'h5e};
  logic [15:0] rv[5] = '{16'h0000, 16'h0000, 16'h0008, 16'h0000, 16'h0000};
  int miscompares = 0;
  int tests_run = 0;
  odes_top #(.SETTLE_CYCLES(SETTLE)) i_odes_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .ctrl_o(ctrl_o), .settle_wait_o(settle_wait_o));
  odes_host i_odes_host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_odes_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_odes_host.xfer(1'b0, a, 16'h0000, q);
    chk("read", e, q);
  endtask
  // outputs trail a write by up to two edges; sample on the falling edge
  task automatic look(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    look(0);
    chk("ground", 16'h000f, {12'h000, ctrl_o.short_to_ground});
    foreach (idx[i]) rd(idx[i], rv[i]);
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'h0000);
    wr(8'h21, 16'h0048);
    rd(8'h21, 16'h0048);
    look(2);
    chk("osr", 16'h0001, {15'h0000, ctrl_o.dac_double_oversample});
    wr(8'h0e, 16'h0002);
    wr(8'h0f, 16'h0001);
    wr(8'h60, 16'h0005);
    look(2);
    chk("amps", 16'h0009, {12'h000, ctrl_o.hp_amp, ctrl_o.line_amp});
    chk("mux", 16'h0005, {12'h000, ctrl_o.out_mux});
    wr(8'h5a, 16'h0011);
    wr(8'h5a, 16'h0033);
    look(0);
    chk("early", 16'h0011, {8'h00, ctrl_o.hp});
    chk("settle", 16'h000c, {12'h000, settle_wait_o});
    rd(8'h61, 16'h000c);
    look(SETTLE + 4);
    chk("mid", 16'h0033, {8'h00, ctrl_o.hp});
    wr(8'h5a, 16'h0077);
    wr(8'h5a, 16'h00ff);
    look(2);
    chk("released", 16'h0003, {12'h000, ctrl_o.short_to_ground});
    wr(8'h5a, 16'h0077);
    look(2);
    chk("reshort", 16'h000f, {12'h000, ctrl_o.short_to_ground});
    wr(8'h5a, 16'h0000);
    wr(8'h5e, 16'h00ff);
    rd(8'h5e, 16'h00ff);
    look(SETTLE + 4);
    chk("line", 16'h00ff, {8'h00, ctrl_o.line});
    chk("hp off", 16'h000c, {4'h0, ctrl_o.hp, ctrl_o.short_to_ground});
    rd(8'h61, 16'h0000);
    close_out;
  end
endmodule
